// File: verilog/tsl_pkg.sv
// Constants shared by both ends of the turn-taking serial link
// Notes on behaviour
// - Host leads with command, sensor answers
// - Strap low selects turn-taking, else slave-only
// - Host stays slave unless sending a command
// - All data on shared MOSI; MISO unused
// - Master shifts on fall, receiver samples rise
// - Clock low around frame-select changes, idles low
// - Frame-select low across byte, idles floated high
// - Sensor as master drives frame-select itself
// - One or two framed bytes, 50 us apart
// - Host releases clock and data after command
// - Sensor answers after delay, frames each byte
// - Host accepts answer bytes up to 3 ms apart, first within 1000 ms
// - Host waits answer plus 1 ms before next
// - No-data commands echo command byte after work
// - Data commands return only their data
// - Unknown commands ignored; host times out
// - Reset after setup writes copies storage to backup
// - Storage/backup mismatch sets status bit 4, indicator
// - Uncopied setup write also sets bit 4
// - Reset restores storage unless write was intended
// - Host resets sensor on unexplained error bit
// - Lock only in write direction, backed up
// - Read direction after reset until changed
package tsl_pkg;
    localparam int BYTE_W = 8;
    localparam logic [7:0] CMD_GET = 8'h67;
    localparam logic [7:0] CMD_PUT = 8'h70;
    localparam logic [7:0] CMD_LOCK = 8'h4C;
    localparam logic [7:0] CMD_STATUS = 8'h37;
    localparam logic [7:0] CMD_SETUP = 8'h41;
    localparam logic [7:0] UPSET_MASK = 8'h01;
    localparam int STAT_ERR_BIT = 4;
    localparam int CLK_NS = 25;
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CMD_GAP_US = 50;
    localparam int CMD_GAP_CYC = (CMD_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SEQ_GAP_MS = 1;
    localparam int SEQ_GAP_CYC = (SEQ_GAP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int RESP_WAIT_MS = 1000;
    localparam int RESP_WAIT_CYC = RESP_WAIT_MS * (1000000 / CLK_NS);
    localparam int BYTE_GAP_MS = 3;
    localparam int BYTE_GAP_CYC = BYTE_GAP_MS * (1000000 / CLK_NS);
    localparam int PROC_US = 300;
    localparam int PROC_CYC = (PROC_US * 1000 + CLK_NS - 1) / CLK_NS;
endpackage

// File: verilog/tsl_if.sv
// Shared three-wire link: per-end drivers and resolved line levels
`timescale 1ns/1ps
interface tsl_if;
    logic h_sck;
    logic h_sck_oe;
    logic h_mosi;
    logic h_mosi_oe;
    logic h_ss;
    logic h_ss_oe;
    logic d_sck;
    logic d_sck_oe;
    logic d_mosi;
    logic d_mosi_oe;
    logic d_ss;
    logic d_ss_oe;
    logic sck;
    logic mosi;
    logic ss;
    // Pulldown on the clock, pullups on data and frame-select
    assign sck = h_sck_oe ? h_sck : (d_sck_oe ? d_sck : 1'b0);
    assign mosi = h_mosi_oe ? h_mosi : (d_mosi_oe ? d_mosi : 1'b1);
    assign ss = h_ss_oe ? h_ss : (d_ss_oe ? d_ss : 1'b1);
    modport host (
        output h_sck, h_sck_oe, h_mosi, h_mosi_oe, h_ss, h_ss_oe,
        input sck, mosi, ss
    );
    modport dev (
        output d_sck, d_sck_oe, d_mosi, d_mosi_oe, d_ss, d_ss_oe,
        input sck, mosi, ss
    );
endinterface

// File: verilog/tsl_host.sv
// Host end: sends commands as master, then listens as slave
`timescale 1ns/1ps
module tsl_host #(
    parameter int HALF_CYC = tsl_pkg::SCK_HALF_CYC,
    parameter int CMD_GAP_CYC = tsl_pkg::CMD_GAP_CYC,
    parameter int SEQ_GAP_CYC = tsl_pkg::SEQ_GAP_CYC,
    parameter int RESP_WAIT_CYC = tsl_pkg::RESP_WAIT_CYC,
    parameter int BYTE_GAP_CYC = tsl_pkg::BYTE_GAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_two,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] cmd_operand,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [7:0] resp_byte,
    output logic resp_timeout,
    tsl_if.host lk
);
    typedef enum {H_IDLE, H_TAKE, H_LEAD, H_HI, H_LO, H_TAIL, H_REL, H_GAP, H_WAIT,
        H_HOLD} tsl_hstate_e;
    tsl_hstate_e state;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic sck_s, mosi_s, ss_s, sck_q, ss_q;
    logic [7:0] rx_sh, tx_sh, operand;
    logic [3:0] rx_cnt, tx_cnt;
    logic rx_done, two_left, got;
    logic [31:0] timer;

    always_ff @(posedge clk_sys) begin
        sy1 <= {lk.sck, lk.mosi, lk.ss};
        sy2 <= sy1;
    end
    assign {sck_s, mosi_s, ss_s} = sy2;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            ss_q <= 1'b1;
            rx_cnt <= '0;
            rx_sh <= '0;
            rx_done <= 1'b0;
        end else begin
            sck_q <= sck_s;
            ss_q <= ss_s;
            rx_done <= 1'b0;
            if (state != H_WAIT || (ss_q && !ss_s)) begin
                rx_cnt <= '0;
            end else if (!ss_s && sck_s && !sck_q) begin
                rx_sh <= {rx_sh[6:0], mosi_s};
                rx_cnt <= rx_cnt + 4'h1;
            end else if (!ss_q && ss_s) begin
                rx_done <= (rx_cnt == 4'(tsl_pkg::BYTE_W));
                rx_cnt <= '0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= H_IDLE;
            cmd_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_byte <= '0;
            resp_timeout <= 1'b0;
            tx_sh <= '0;
            operand <= '0;
            tx_cnt <= '0;
            two_left <= 1'b0;
            got <= 1'b0;
            timer <= '0;
            // Slave between commands: every driver off
            lk.h_sck <= 1'b0;
            lk.h_sck_oe <= 1'b0;
            lk.h_mosi <= 1'b0;
            lk.h_mosi_oe <= 1'b0;
            lk.h_ss <= 1'b1;
            lk.h_ss_oe <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            resp_timeout <= 1'b0;
            if (state != H_IDLE && state != H_WAIT && timer != '0) begin
                timer <= timer - 32'h1;
            end else begin
                unique case (state)
                    H_IDLE: begin
                        cmd_ready <= 1'b1;
                        if (cmd_valid && cmd_ready) begin
                            cmd_ready <= 1'b0;
                            tx_sh <= cmd_byte;
                            operand <= cmd_operand;
                            two_left <= cmd_two;
                            state <= H_TAKE;
                        end
                    end
                    H_TAKE: begin
                        lk.h_sck <= 1'b0;
                        lk.h_sck_oe <= 1'b1;
                        lk.h_mosi <= tx_sh[7];
                        lk.h_mosi_oe <= 1'b1;
                        timer <= 32'(HALF_CYC - 1);
                        tx_cnt <= '0;
                        state <= H_LEAD;
                    end
                    H_LEAD: begin
                        lk.h_ss <= 1'b0;
                        lk.h_ss_oe <= 1'b1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= H_LO;
                    end
                    H_LO: begin
                        lk.h_sck <= 1'b1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= H_HI;
                    end
                    H_HI: begin
                        lk.h_sck <= 1'b0;
                        lk.h_mosi <= tx_sh[6];
                        tx_sh <= tx_sh << 1;
                        tx_cnt <= tx_cnt + 4'h1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= (tx_cnt == 4'(tsl_pkg::BYTE_W - 1)) ? H_TAIL : H_LO;
                    end
                    H_TAIL: begin
                        lk.h_ss_oe <= 1'b0;
                        timer <= 32'(HALF_CYC - 1);
                        state <= H_REL;
                    end
                    H_REL: begin
                        lk.h_sck_oe <= 1'b0;
                        lk.h_mosi_oe <= 1'b0;
                        if (two_left) begin
                            two_left <= 1'b0;
                            tx_sh <= operand;
                            timer <= 32'(CMD_GAP_CYC - 1);
                            state <= H_GAP;
                        end else begin
                            got <= 1'b0;
                            timer <= 32'(RESP_WAIT_CYC - 1);
                            state <= H_WAIT;
                        end
                    end
                    H_GAP: state <= H_TAKE;
                    H_WAIT: begin
                        // Each answer byte must come within BYTE_GAP_CYC of the previous one
                        if (rx_done) begin
                            resp_valid <= 1'b1;
                            resp_byte <= rx_sh;
                            got <= 1'b1;
                            timer <= 32'(BYTE_GAP_CYC - 1);
                        end else if (timer != '0) begin
                            timer <= timer - 32'h1;
                        end else begin
                            resp_timeout <= !got;
                            timer <= 32'(SEQ_GAP_CYC - 1);
                            state <= H_HOLD;
                        end
                    end
                    H_HOLD: state <= H_IDLE;
                endcase
            end
        end
    end
endmodule // tsl_host

// File: verilog/tsl_dev.sv
// Sensor end: listens as slave, answers as master, guards setup storage
`timescale 1ns/1ps
module tsl_dev #(
    parameter int NSET = 8,
    parameter int HALF_CYC = tsl_pkg::SCK_HALF_CYC,
    parameter int PROC_CYC = tsl_pkg::PROC_CYC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic role_select_strap,
    input wire logic nv_init,
    input wire logic storage_upset,
    output logic indicator,
    output logic turn_mode,
    tsl_if.dev lk
);
    typedef enum {D_RESTORE, D_IDLE, D_PROC, D_TAKE, D_LEAD, D_HI, D_LO, D_TAIL,
        D_REL} tsl_dstate_e;
    localparam int IW = $clog2(NSET);
    localparam logic [IW-1:0] LOCK_IDX = IW'(NSET - 1);
    localparam logic [IW-1:0] LAST_SET = IW'(NSET - 2);
    tsl_dstate_e state;
    tsl_dstate_e resp_state;
    // Storage and its backup stand outside the reset: they model non-volatile cells
    logic [7:0] setup_mem [NSET];
    logic [7:0] backup_mem [NSET];
    logic dirty;
    logic mismatch;
    logic err_flag;
    logic [IW-1:0] idx;
    logic [IW-1:0] ptr;
    logic put_mode;
    logic op_pending;
    logic [7:0] cmd;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic sck_s, mosi_s, ss_s, strap_s, sck_q, ss_q;
    logic [7:0] rx_sh, tx_sh;
    logic [3:0] rx_cnt, tx_cnt;
    logic rx_done;
    logic wr_en;
    logic [IW-1:0] wr_idx;
    logic [7:0] wr_data;
    logic [31:0] timer;

    always_ff @(posedge clk_sys) begin
        sy1 <= {lk.sck, lk.mosi, lk.ss, role_select_strap};
        sy2 <= sy1;
    end
    assign {sck_s, mosi_s, ss_s, strap_s} = sy2;

    // Byte receiver, active only while the sensor is slave and idle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sck_q <= 1'b0;
            ss_q <= 1'b1;
            rx_cnt <= '0;
            rx_sh <= '0;
            rx_done <= 1'b0;
        end else begin
            sck_q <= sck_s;
            ss_q <= ss_s;
            rx_done <= 1'b0;
            if (state != D_IDLE || (ss_q && !ss_s)) begin
                rx_cnt <= '0;
            end else if (!ss_s && sck_s && !sck_q) begin
                rx_sh <= {rx_sh[6:0], mosi_s};
                rx_cnt <= rx_cnt + 4'h1;
            end else if (!ss_q && ss_s) begin
                // Partial bytes are dropped rather than guessed at
                rx_done <= (rx_cnt == 4'(tsl_pkg::BYTE_W));
                rx_cnt <= '0;
            end
        end
    end

    // Continuous compare of every storage word against its backup
    always_comb begin
        mismatch = 1'b0;
        for (int i = 0; i < NSET; i++) begin
            if (setup_mem[i] != backup_mem[i]) begin
                mismatch = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            err_flag <= 1'b0;
            indicator <= 1'b0;
        end else begin
            err_flag <= mismatch | dirty;
            indicator <= mismatch | dirty;
        end
    end

    // Storage: restore walk after reset, command writes, injected upsets
    always_ff @(posedge clk_sys) begin
        if (nv_init) begin
            for (int i = 0; i < NSET; i++) begin
                setup_mem[i] <= '0;
                backup_mem[i] <= '0;
            end
            dirty <= 1'b0;
        end else if (state == D_RESTORE) begin
            if (dirty) begin
                backup_mem[idx] <= setup_mem[idx];
            end else begin
                setup_mem[idx] <= backup_mem[idx];
            end
            if (rstn && idx == LOCK_IDX) begin
                dirty <= 1'b0;
            end
        end else begin
            if (storage_upset) begin
                setup_mem[0] <= setup_mem[0] ^ tsl_pkg::UPSET_MASK;
            end
            if (wr_en) begin
                setup_mem[wr_idx] <= wr_data;
                dirty <= 1'b1;
            end
        end
    end

    // Slave-only mode still decodes but never takes the line
    assign resp_state = turn_mode ? D_PROC : D_IDLE;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state <= D_RESTORE;
            idx <= '0;
            ptr <= '0;
            put_mode <= 1'b0;
            op_pending <= 1'b0;
            cmd <= '0;
            tx_sh <= '0;
            tx_cnt <= '0;
            timer <= '0;
            wr_en <= 1'b0;
            wr_idx <= '0;
            wr_data <= '0;
            turn_mode <= 1'b0;
            lk.d_sck <= 1'b0;
            lk.d_sck_oe <= 1'b0;
            lk.d_mosi <= 1'b0;
            lk.d_mosi_oe <= 1'b0;
            lk.d_ss <= 1'b1;
            lk.d_ss_oe <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (state != D_RESTORE && state != D_IDLE && timer != '0) begin
                timer <= timer - 32'h1;
            end else begin
                unique case (state)
                    D_RESTORE: begin
                        idx <= idx + 1'b1;
                        if (idx == LOCK_IDX) begin
                            // Strap sampled well after release, once synchronised
                            turn_mode <= !strap_s;
                            state <= D_IDLE;
                        end
                    end
                    D_IDLE: begin
                        if (rx_done) begin
                            timer <= 32'(PROC_CYC - 1);
                            if (op_pending) begin
                                op_pending <= 1'b0;
                                wr_en <= 1'b1;
                                wr_idx <= ptr;
                                wr_data <= rx_sh;
                                ptr <= (ptr == LAST_SET) ? '0 : ptr + 1'b1;
                                tx_sh <= cmd;
                                state <= resp_state;
                            end else begin
                                cmd <= rx_sh;
                                if (rx_sh == tsl_pkg::CMD_GET || rx_sh == tsl_pkg::CMD_PUT) begin
                                    put_mode <= (rx_sh == tsl_pkg::CMD_PUT);
                                    tx_sh <= rx_sh;
                                    state <= resp_state;
                                end else if (rx_sh == tsl_pkg::CMD_LOCK && put_mode) begin
                                    wr_en <= 1'b1;
                                    wr_idx <= LOCK_IDX;
                                    wr_data <= setup_mem[LOCK_IDX] + 8'h01;
                                    tx_sh <= rx_sh;
                                    state <= resp_state;
                                end else if (rx_sh == tsl_pkg::CMD_STATUS) begin
                                    tx_sh <= 8'(err_flag) << tsl_pkg::STAT_ERR_BIT;
                                    state <= resp_state;
                                end else if (rx_sh == tsl_pkg::CMD_SETUP) begin
                                    if (put_mode) begin
                                        op_pending <= 1'b1;
                                    end else begin
                                        tx_sh <= setup_mem[ptr];
                                        state <= resp_state;
                                    end
                                end
                                // Anything else falls through unanswered
                            end
                        end
                    end
                    D_PROC: begin
                        // Clock and data first, frame-select a half period later
                        lk.d_sck <= 1'b0;
                        lk.d_sck_oe <= 1'b1;
                        lk.d_mosi <= tx_sh[7];
                        lk.d_mosi_oe <= 1'b1;
                        tx_cnt <= '0;
                        timer <= 32'(HALF_CYC - 1);
                        state <= D_TAKE;
                    end
                    D_TAKE: begin
                        lk.d_ss <= 1'b0;
                        lk.d_ss_oe <= 1'b1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= D_LO;
                    end
                    D_LO: begin
                        lk.d_sck <= 1'b1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= D_HI;
                    end
                    D_HI: begin
                        lk.d_sck <= 1'b0;
                        lk.d_mosi <= tx_sh[6];
                        tx_sh <= tx_sh << 1;
                        tx_cnt <= tx_cnt + 4'h1;
                        timer <= 32'(HALF_CYC - 1);
                        state <= (tx_cnt == 4'(tsl_pkg::BYTE_W - 1)) ? D_TAIL : D_LO;
                    end
                    D_TAIL: begin
                        lk.d_ss_oe <= 1'b0;
                        timer <= 32'(HALF_CYC - 1);
                        state <= D_LEAD;
                    end
                    D_LEAD: begin
                        lk.d_sck_oe <= 1'b0;
                        lk.d_mosi_oe <= 1'b0;
                        state <= D_REL;
                    end
                    D_REL: state <= D_IDLE;
                endcase
            end
        end
    end
endmodule // tsl_dev

// File: tb/tsl_assertions.sv
// Concurrent checks on the shared three-wire link
`timescale 1ns/1ps
module tsl_assertions (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic h_sck_oe,
    input wire logic h_mosi_oe,
    input wire logic h_ss_oe,
    input wire logic d_sck_oe,
    input wire logic d_mosi_oe,
    input wire logic d_ss_oe,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss
);
    logic [3:0] nbit;
    // Clock rises inside the current frame
    always_ff @(posedge clk_sys) begin
        if (!rstn || ss)
            nbit <= 4'h0;
        else if ($rose(sck))
            nbit <= nbit + 4'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sck_owner_a: assert property (!(h_sck_oe && d_sck_oe))
        else $error("both ends drive the clock");
    mosi_owner_a: assert property (!(h_mosi_oe && d_mosi_oe))
        else $error("both ends drive the data line");
    ss_edge_a: assert property ($changed(ss) |-> !sck && !$past(sck))
        else $error("frame-select moved with clock high");
    idle_low_a: assert property (ss |-> !sck)
        else $error("clock high outside a frame");
    data_hold_a: assert property ($rose(sck) |-> $stable(mosi))
        else $error("data moved at a rising clock");
    frame_clock_a: assert property ($rose(sck) |-> !ss)
        else $error("clock rise outside a frame");
    bit_count_a: assert property ($rose(ss) |-> nbit == 4'h8)
        else $error("frame did not carry eight bits");
    host_release_a: assert property ($fell(h_ss_oe) |-> ##[1:8] (!h_sck_oe && !h_mosi_oe))
        else $error("host kept the lines after a byte");
    dev_frame_a: assert property (d_ss_oe |-> d_sck_oe && d_mosi_oe)
        else $error("sensor framed without owning the lines");
endmodule // tsl_assertions

// File: tb/testbench.sv
// Self-checking bench joining host and sensor ends of the link
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_two = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic [7:0] cmd_operand = 8'h00;
    logic role_select_strap = 1'b0;
    logic nv_init = 1'b0;
    logic storage_upset = 1'b0;
    logic cmd_ready, resp_valid, resp_timeout, indicator, turn_mode;
    logic [7:0] resp_byte;
    logic [7:0] wire_byte = 8'h00;
    logic [1:0] got;
    logic [7:0] rb;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    tsl_if tsl_if_i ();
    // Short gaps keep the run small; the host times these itself
    tsl_host #(.SEQ_GAP_CYC(40), .RESP_WAIT_CYC(2000), .BYTE_GAP_CYC(300), .CMD_GAP_CYC(20))
        tsl_host_i (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_two(cmd_two),
        .cmd_byte(cmd_byte), .cmd_operand(cmd_operand), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_timeout(resp_timeout),
        .lk(tsl_if_i));
    tsl_dev #(.PROC_CYC(50)) tsl_dev_i (.clk_sys(clk_sys), .rstn(rstn),
        .role_select_strap(role_select_strap), .nv_init(nv_init),
        .storage_upset(storage_upset), .indicator(indicator), .turn_mode(turn_mode),
        .lk(tsl_if_i));
    tsl_assertions tsl_assertions_i (.clk_sys(clk_sys), .rstn(rstn),
        .h_sck_oe(tsl_if_i.h_sck_oe), .h_mosi_oe(tsl_if_i.h_mosi_oe),
        .h_ss_oe(tsl_if_i.h_ss_oe), .d_sck_oe(tsl_if_i.d_sck_oe),
        .d_mosi_oe(tsl_if_i.d_mosi_oe), .d_ss_oe(tsl_if_i.d_ss_oe),
        .sck(tsl_if_i.sck), .mosi(tsl_if_i.mosi), .ss(tsl_if_i.ss));
    always #12.5 clk_sys = ~clk_sys;
    // Last frame as seen on the wire, first bit in the top
    always @(posedge tsl_if_i.sck) begin
        if (!tsl_if_i.ss)
            wire_byte <= {wire_byte[6:0], tsl_if_i.mosi};
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("n_fail=%0d tests_run=%0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (act !== exp)
            $display("[FAIL] t=%0t got %h expected %h", $time, act, exp);
        if (act !== exp)
            n_fail = n_fail + 1;
    endtask
    task automatic do_reset(input logic strap);
        @(negedge clk_sys);
        rstn = 1'b0;
        role_select_strap = strap;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (16) @(negedge clk_sys);
    endtask
    // One command sequence; eg 01 = answer byte eb, 10 = silence
    task automatic ask(input logic [7:0] c, input logic two, input logic [7:0] op,
        input logic [1:0] eg, input logic [7:0] eb);
        int i;
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
        cmd_byte = c;
        cmd_two = two;
        cmd_operand = op;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (i = 0; i < 3000 && resp_valid !== 1'b1 && resp_timeout !== 1'b1; i++)
            @(negedge clk_sys);
        got = {resp_timeout, resp_valid};
        rb = resp_byte;
        for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) @(negedge clk_sys);
        // A hold that never ends must count against the run
        chk({7'h00, cmd_ready}, 8'h01);
        chk({6'h00, got}, {6'h00, eg});
        // Wire holds the answer, or the last command byte if none came
        chk(wire_byte, eg == 2'b01 ? eb : (two ? op : c));
        if (eg == 2'b01)
            chk(rb, eb);
    endtask
    task automatic t_strap();
        do_reset(1'b1);
        chk({7'h00, turn_mode}, 8'h00);
        ask(tsl_pkg::CMD_GET, 1'b0, 8'h00, 2'b10, 8'h00);
        do_reset(1'b0);
        chk({7'h00, turn_mode}, 8'h01);
    endtask
    task automatic t_direction();
        ask(tsl_pkg::CMD_LOCK, 1'b0, 8'h00, 2'b10, 8'h00);
        ask(tsl_pkg::CMD_GET, 1'b0, 8'h00, 2'b01, tsl_pkg::CMD_GET);
        ask(8'h00, 1'b0, 8'h00, 2'b10, 8'h00);
        ask(tsl_pkg::CMD_PUT, 1'b0, 8'h00, 2'b01, tsl_pkg::CMD_PUT);
        ask(tsl_pkg::CMD_LOCK, 1'b0, 8'h00, 2'b01, tsl_pkg::CMD_LOCK);
    endtask
    task automatic t_setup();
        ask(tsl_pkg::CMD_SETUP, 1'b1, 8'h5A, 2'b01, tsl_pkg::CMD_SETUP);
        chk({7'h00, indicator}, 8'h01);
        ask(tsl_pkg::CMD_STATUS, 1'b0, 8'h00, 2'b01, 8'h10);
        do_reset(1'b0);
        chk({7'h00, indicator}, 8'h00);
        ask(tsl_pkg::CMD_STATUS, 1'b0, 8'h00, 2'b01, 8'h00);
        ask(tsl_pkg::CMD_SETUP, 1'b0, 8'h00, 2'b01, 8'h5A);
    endtask
    task automatic t_upset();
        @(negedge clk_sys);
        storage_upset = 1'b1;
        @(negedge clk_sys);
        storage_upset = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({7'h00, indicator}, 8'h01);
        ask(tsl_pkg::CMD_STATUS, 1'b0, 8'h00, 2'b01, 8'h10);
        do_reset(1'b0);
        chk({7'h00, indicator}, 8'h00);
        ask(tsl_pkg::CMD_SETUP, 1'b0, 8'h00, 2'b01, 8'h5A);
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        nv_init = 1'b1;
        repeat (2) @(negedge clk_sys);
        nv_init = 1'b0;
        repeat (16) @(negedge clk_sys);
        t_strap();
        t_direction();
        t_setup();
        t_upset();
        close_out();
    end
endmodule // testbench
